// ### wwdcm_pkg.sv
// package for the window watchdog and clock monitor block
// assumes one 50 MHz clock and a plain address/strobe register port
package wwdcm_pkg;
    // register map
    localparam logic [3:0] WWDCM_ADDR_SERVICE = 4'h0;
    localparam logic [3:0] WWDCM_ADDR_STATUS = 4'h1;
    // service register layout
    localparam int WWDCM_WIN_HI = 7;
    localparam int WWDCM_WIN_LO = 6;
    localparam int WWDCM_KEY_HI = 5;
    localparam int WWDCM_KEY_LO = 1;
    localparam int WWDCM_MON_BIT = 0;
    localparam logic [4:0] WWDCM_KEY = 5'h0C;
    localparam logic [1:0] WWDCM_WIN_RESET = 2'h3;
    localparam logic WWDCM_MON_RESET = 1'b1;
    // window limits in timebase clocks
    localparam logic [16:0] WWDCM_LOWER_LIMIT = 17'h00800;
    localparam logic [16:0] WWDCM_UPPER_8K = 17'h02000;
    // fault stretch after the pin falls: 16 to 32 clocks, we use 24
    localparam logic [5:0] WWDCM_STRETCH = 6'h18;
    // clock monitor: a gap of 2 ms between cycle ticks is 500 Hz, above
    // 10 Hz and below 5 kHz
    localparam int WWDCM_MON_GAP_US = 2000;
    localparam int WWDCM_CLK_MHZ = 50;
    localparam int WWDCM_MON_GAP_CYC = WWDCM_MON_GAP_US * WWDCM_CLK_MHZ;

    typedef enum {
        WWDCM_IDLE_ST,
        WWDCM_PULL_ST,
        WWDCM_STRETCH_ST,
        WWDCM_WAIT_HIGH_ST
    } wwdcm_fault_t;

    typedef struct packed {
        logic halt;
        logic idle;
        logic boot_rom;
    } wwdcm_power_t;
endpackage : wwdcm_pkg

// ### wwdcm_top.sv
// window watchdog with keyed service register and clock monitor
// assumes all inputs synchronous to clock; the pin wire is resolved outside
`timescale 1ns/1ns

// Functional notes
// R1: watchdog active only while option bit 2 is zero; pin pulled up idle.
// R2: both detectors held inactive while reset is asserted.
// R3: after reset window select is 11 and monitor enabled, watchdog armed.
// R4: window select 00..11 gives 8k,16k,32k,64k upper; lower fixed 2048.
// R5: service bit 0 disables (0) or enables (1) the clock monitor.
// R6: first keyed write fixes window and monitor enable until reset.
// R7: first service write with wrong key is a watchdog error.
// R8: later writes must match all fields; match restarts, mismatch errors.
// R9: no valid service before upper limit raises a watchdog error.
// R10: service before lower limit since restart is an error.
// R11: first service after reset may come any time, no lower-limit error.
// R12: boot ROM entry suppresses lower limit and services; return services.
// R13: on error drive pin low, then 16-32 cycles after it reads low, release.
// R14: window restarts when the pin returns high after an error.
// R15: service writes while the fault is asserted are ignored.
// R16: slow clock holds the pin low; release 16-32 cycles after recovery.
// R17: never reject 5 kHz or faster; always reject below 10 Hz.
// R18: reads return zeros in the key field.
// R19: timeout detector inhibited in halt and idle.
// R20: clock monitor stays active in halt and idle.
// R21: leaving halt reloads window; leaving idle performs a hardware service.
// R22: service register: window bits 7:6, key bits 5:1, monitor bit 0.
// R23: all window limits counted in idle timebase clocks.
// R24: a valid service clears the window counter.
module wwdcm_top #(
    parameter int MON_GAP_CYC = wwdcm_pkg::WWDCM_MON_GAP_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // timing and core status
    input wire logic option_wd_disable,
    input wire logic idle_timebase,
    input wire logic instruction_cycle,
    input wire wwdcm_pkg::wwdcm_power_t power_mode,
    // fault pin, open drain
    input wire logic fault_pin_in,
    output logic fault_pin_out,
    output logic fault_pin_oe,
    output logic fault_out
);
    import wwdcm_pkg::*;

    initial begin
        if (MON_GAP_CYC < 2)
        begin
            $error("MON_GAP_CYC too small");
        end
        if (WWDCM_STRETCH < 6'h10 || WWDCM_STRETCH > 6'h20)
        begin
            $error("fault stretch outside 16 to 32 clocks");
        end
    end

    function automatic logic [16:0] upper_limit(input logic [1:0] sel);
        upper_limit = WWDCM_UPPER_8K << sel;
    endfunction : upper_limit

    // true when the key field of a written value carries the fixed key
    function automatic logic key_ok(input logic [7:0] value);
        key_ok = value[WWDCM_KEY_HI:WWDCM_KEY_LO] == WWDCM_KEY;
    endfunction : key_ok

    // ----------------------------------------------------------------
    // service register
    // ----------------------------------------------------------------
    logic [1:0] win_q;
    logic mon_en_q;
    logic configured_q;
    logic first_done_q;
    logic wd_active;
    logic fault_busy;
    logic svc_write;
    logic svc_match;
    logic svc_error;
    logic svc_valid;
    logic too_early;
    logic lower_en_q;
    logic [16:0] count_q;
    logic hw_service;
    logic timeout;
    logic wd_error;
    logic mon_fail_q;
    wwdcm_power_t power_q;
    wwdcm_fault_t state_q;
    logic boot_edge;
    logic idle_exit;
    logic halt_exit;
    logic restart;
    logic counting;
    logic fault_d;

    assign wd_active = ~option_wd_disable; // R1
    // writes during any fault, monitor faults included, are dropped
    assign svc_write = reg_write && reg_addr == WWDCM_ADDR_SERVICE &&
        wd_active && !fault_busy && !fault_out; // R15
    assign svc_match = key_ok(reg_wdata) &&
        reg_wdata[WWDCM_WIN_HI:WWDCM_WIN_LO] == win_q &&
        reg_wdata[WWDCM_MON_BIT] == mon_en_q; // R8
    assign too_early = first_done_q && lower_en_q &&
        count_q < WWDCM_LOWER_LIMIT; // R10 R11
    assign svc_error = svc_write && (too_early ||
        (configured_q ? !svc_match : !key_ok(reg_wdata))); // R7 R8
    assign svc_valid = svc_write && !svc_error;

    // the first keyed write fixes window and monitor enable until reset

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            win_q <= WWDCM_WIN_RESET; // R3
            mon_en_q <= WWDCM_MON_RESET; // R3
            configured_q <= 1'b0;
        end
        else if (svc_valid && !configured_q)
        begin
            win_q <= reg_wdata[WWDCM_WIN_HI:WWDCM_WIN_LO]; // R6 R22
            mon_en_q <= reg_wdata[WWDCM_MON_BIT]; // R5
            configured_q <= 1'b1; // R6
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            first_done_q <= 1'b0;
        end
        else if (svc_write)
        begin
            first_done_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // the key field always reads back as zeros
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_read)
        begin
            case (reg_addr)
                WWDCM_ADDR_SERVICE: reg_rdata <= {win_q, 5'h00, mon_en_q}; // R18
                WWDCM_ADDR_STATUS: reg_rdata <= {4'h0, mon_fail_q, fault_busy,
                    configured_q, lower_en_q};
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // power mode edges
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            power_q <= '0;
        end
        else
        begin
            power_q <= power_mode;
        end
    end

    // boot ROM edges, idle exit and halt exit all act as a service
    assign boot_edge = power_mode.boot_rom != power_q.boot_rom; // R12
    assign idle_exit = power_q.idle && !power_mode.idle; // R21
    assign halt_exit = power_q.halt && !power_mode.halt; // R21
    assign hw_service = boot_edge || idle_exit || halt_exit;

    // ----------------------------------------------------------------
    // window counter
    // ----------------------------------------------------------------

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lower_en_q <= 1'b1;
        end
        else if (boot_edge)
        begin
            lower_en_q <= !power_mode.boot_rom; // R12
        end
    end

    assign timeout = wd_active && !power_mode.halt && !power_mode.idle &&
        count_q >= upper_limit(win_q); // R9 R19 R4

    // the window restarts once the pin reads high again after an error
    assign restart = state_q == WWDCM_WAIT_HIGH_ST && fault_pin_in; // R14
    // the count sleeps in halt and idle and while the pin sequence runs
    assign counting = idle_timebase && state_q == WWDCM_IDLE_ST &&
        !power_mode.halt && !power_mode.idle; // R19 R23

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= 17'h00000; // R2
        end
        else if (svc_valid || hw_service || restart)
        begin
            count_q <= 17'h00000; // R24 R14
        end
        else if (counting && count_q < upper_limit(win_q))
        begin
            count_q <= count_q + 17'h00001; // R23
        end
    end

    // ----------------------------------------------------------------
    // error collection
    // ----------------------------------------------------------------
    assign wd_error = svc_error || timeout;

    // ----------------------------------------------------------------
    // clock monitor
    // ----------------------------------------------------------------
    // a cycle tick clears the gap; a gap too long flags a slow clock
    logic [31:0] gap_q;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap_q <= 32'h00000000;
            mon_fail_q <= 1'b0; // R2
        end
        else if (instruction_cycle || !mon_en_q || !wd_active)
        begin
            gap_q <= 32'h00000000;
            mon_fail_q <= 1'b0; // R16
        end
        else if (gap_q >= 32'(MON_GAP_CYC - 1))
        begin
            mon_fail_q <= 1'b1; // R17 R20
        end
        else
        begin
            gap_q <= gap_q + 32'h00000001;
        end
    end

    // ----------------------------------------------------------------
    // fault output sequencer
    // ----------------------------------------------------------------
    logic [5:0] stretch_q;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= WWDCM_IDLE_ST; // R2
            stretch_q <= 6'h00;
        end
        else
        begin
            case (state_q)
                WWDCM_IDLE_ST:
                begin
                    if (wd_error)
                    begin
                        state_q <= WWDCM_PULL_ST; // R13
                    end
                end
                WWDCM_PULL_ST:
                begin
                    stretch_q <= 6'h00;
                    if (!fault_pin_in)
                    begin
                        state_q <= WWDCM_STRETCH_ST; // R13
                    end
                end
                WWDCM_STRETCH_ST:
                begin
                    stretch_q <= stretch_q + 6'h01;
                    if (stretch_q == WWDCM_STRETCH - 6'h01)
                    begin
                        state_q <= WWDCM_WAIT_HIGH_ST; // R13
                    end
                end
                WWDCM_WAIT_HIGH_ST:
                begin
                    if (fault_pin_in)
                    begin
                        state_q <= WWDCM_IDLE_ST; // R14
                    end
                end
                default: state_q <= WWDCM_IDLE_ST;
            endcase
        end
    end

    // monitor release stretch after recovery
    logic [5:0] mon_hold_q;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mon_hold_q <= 6'h00;
        end
        else if (mon_fail_q)
        begin
            mon_hold_q <= WWDCM_STRETCH; // R16
        end
        else if (mon_hold_q != 6'h00)
        begin
            mon_hold_q <= mon_hold_q - 6'h01;
        end
    end

    assign fault_busy = state_q != WWDCM_IDLE_ST;

    // pull the line while the sequencer holds it, on a fresh error, or
    // while the monitor flags a slow clock or its release hold runs
    always_comb
    begin
        fault_d = 1'b0;
        if (wd_active)
        begin
            case (state_q)
                WWDCM_PULL_ST: fault_d = 1'b1; // R13
                WWDCM_STRETCH_ST: fault_d = 1'b1; // R13
                WWDCM_IDLE_ST: fault_d = wd_error;
                default: fault_d = 1'b0;
            endcase
            if (mon_fail_q || mon_hold_q != 6'h00)
            begin
                fault_d = 1'b1; // R16
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fault_out <= 1'b0; // R2
        end
        else
        begin
            fault_out <= fault_d;
        end
    end

    assign fault_pin_out = 1'b0;
    assign fault_pin_oe = fault_out; // R1
endmodule : wwdcm_top

// ### wwdcm_top_asserts.sv
// assertions on the watchdog block ports
// assumes one clock, pin resolved by a pull-up
`timescale 1ns/1ns
module wwdcm_top_asserts
    import wwdcm_pkg::*;
#(
    parameter int MON_GAP_CYC = wwdcm_pkg::WWDCM_MON_GAP_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // timing and status
    input wire logic option_wd_disable,
    input wire logic idle_timebase,
    input wire logic instruction_cycle,
    input wire wwdcm_pkg::wwdcm_power_t power_mode,
    // fault pin
    input wire logic fault_pin_in,
    input wire logic fault_pin_out,
    input wire logic fault_pin_oe,
    input wire logic fault_out
);
    logic [5:0] low_cnt_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ------------------------------
    // cycles of fault with pin low
    // ------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            low_cnt_q <= 6'h00;
        end
        else if (!fault_out)
        begin
            low_cnt_q <= 6'h00;
        end
        else if (!fault_pin_in && low_cnt_q != 6'h3F)
        begin
            low_cnt_q <= low_cnt_q + 6'h01;
        end
    end
    chk_pin_drive_low: assert property (
        fault_pin_out == 1'b0) else $error("pin drive not low");
    chk_disable_quiet: assert property (
        option_wd_disable && $past(option_wd_disable) |-> !fault_out)
        else $error("fault while disabled");
    chk_reset_quiet: assert property (
        $rose(reset_n) |-> !fault_out) else $error("fault at reset exit");
    chk_key_hidden: assert property (
        reg_read && reg_addr == WWDCM_ADDR_SERVICE
        |=> reg_rdata[5:1] == 5'h00) else $error("key readable");
    chk_key_error: assert property (
        reg_write && reg_addr == WWDCM_ADDR_SERVICE
        && reg_wdata[5:1] != WWDCM_KEY && !option_wd_disable
        && fault_pin_in && !fault_out && !$past(fault_out)
        && !$past(fault_out, 2) |=> fault_out)
        else $error("bad key not flagged");
    chk_fault_min: assert property (
        $rose(fault_out) |-> fault_out[*8]) else $error("fault too short");
    chk_stretch_min: assert property (
        $fell(fault_out) |-> low_cnt_q >= 6'h10)
        else $error("released before stretch");
    chk_oe_tracks: assert property (
        fault_pin_oe == fault_out) else $error("enable not fault");
endmodule : wwdcm_top_asserts

bind wwdcm_top wwdcm_top_asserts #(.MON_GAP_CYC(MON_GAP_CYC)) u_chk (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .option_wd_disable(option_wd_disable),
    .idle_timebase(idle_timebase), .instruction_cycle(instruction_cycle),
    .power_mode(power_mode), .fault_pin_in(fault_pin_in),
    .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe),
    .fault_out(fault_out));

// ### wwdcm_pin_model.sv
// fault line with weak pull-up feeding the reset circuit
// assumes the block pulls low while its enable is high
`timescale 1ns/1ns
module wwdcm_pin_model (
    // pin side
    input wire logic pin_oe,
    input wire logic pin_drive,
    output logic pin_level
);
    // pull-up wins when released
    assign pin_level = pin_oe ? pin_drive : 1'b1;
endmodule : wwdcm_pin_model

// ### tb.sv
// self-checking bench for the watchdog block
// assumes the pin model resolves the fault line
`timescale 1ns/1ns
module tb;
    import wwdcm_pkg::*;
    logic clock, reset_n, wr, rd, opt, ic, pin_in, pin_out, oe, fo;
    logic [3:0] addr;
    logic [7:0] wd, rdata, d;
    logic tick;
    wwdcm_power_t pm;
    int n_mismatch, compares, n;
    localparam logic [3:0] SV = WWDCM_ADDR_SERVICE;

    wwdcm_top #(.MON_GAP_CYC(50)) dut (.clock(clock), .reset_n(reset_n),
        .reg_addr(addr), .reg_wdata(wd), .reg_write(wr), .reg_read(rd),
        .reg_rdata(rdata), .option_wd_disable(opt), .idle_timebase(tick),
        .instruction_cycle(ic), .power_mode(pm), .fault_pin_in(pin_in),
        .fault_pin_out(pin_out), .fault_pin_oe(oe), .fault_out(fo));
    wwdcm_pin_model u_pin (.pin_oe(oe), .pin_drive(pin_out),
        .pin_level(pin_in));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ----------------
    // helpers
    // ----------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // counts cycles until the fault output reaches lvl
    task automatic wait_fo(input logic lvl, input int lim);
        n = 0;
        while (fo !== lvl)
        begin
            @(posedge clock);
            #1 n++;
            if (n > lim)
            begin
                n_mismatch++;
                end_of_test;
            end
        end
    endtask : wait_fo
    task automatic do_reset;
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
    endtask : do_reset
    task automatic idle(input int c);
        repeat (c) @(posedge clock);
    endtask : idle
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset_vals;
        do_reset;
        chk(8'(fo), 8'h00);
        rd_reg(SV);
        chk(d, 8'hC1);
        wr_reg(4'h5, 8'h00);
        idle(4);
        chk(8'(fo), 8'h00);
    endtask : t_reset_vals
    task automatic t_bad_key;
        do_reset;
        opt <= 1'b1;
        wr_reg(SV, 8'hC0);
        idle(30);
        chk(8'(fo), 8'h00);
        do_reset;
        opt <= 1'b0;
        wr_reg(SV, 8'hC0);
        wait_fo(1'b1, 3);
        wr_reg(SV, 8'h18);
        wait_fo(1'b0, 40);
        chk(8'(n >= 14 && n <= 34), 8'h01);
        idle(2);
        rd_reg(SV);
        chk(d, 8'hC1);
    endtask : t_bad_key
    task automatic t_windows;
        do_reset;
        wr_reg(SV, 8'h18);
        idle(5);
        chk(8'(fo), 8'h00);
        rd_reg(SV);
        chk(d, 8'h00);
        idle(3000);
        wr_reg(SV, 8'h18);
        idle(6000);
        chk(8'(fo), 8'h00);
        wr_reg(SV, 8'h18);
        wr_reg(SV, 8'h18);
        wait_fo(1'b1, 3);
    endtask : t_windows
    task automatic t_timeout;
        do_reset;
        wr_reg(SV, 8'h18);
        wait_fo(1'b1, 9000);
        chk(8'(n >= 8180 && n <= 8200), 8'h01);
        wait_fo(1'b0, 60);
        idle(2100);
        chk(8'(fo), 8'h00);
        wr_reg(SV, 8'h19);
        wait_fo(1'b1, 3);
    endtask : t_timeout
    task automatic t_monitor;
        do_reset;
        ic <= 1'b0;
        wait_fo(1'b1, 60);
        ic <= 1'b1;
        wait_fo(1'b0, 40);
        chk(8'(n >= 16), 8'h01);
        idle(2);
        wr_reg(SV, 8'h18);
        ic <= 1'b0;
        idle(200);
        chk(8'(fo), 8'h00);
        ic <= 1'b1;
    endtask : t_monitor
    task automatic t_power;
        do_reset;
        wr_reg(SV, 8'h18);
        tick <= 1'b0;
        idle(9000);
        chk(8'(fo), 8'h00);
        tick <= 1'b1;
        idle(3000);
        pm.halt <= 1'b1;
        idle(9000);
        chk(8'(fo), 8'h00);
        pm.halt <= 1'b0;
        wr_reg(SV, 8'h18);
        wait_fo(1'b1, 3);
        do_reset;
        wr_reg(SV, 8'h18);
        idle(100);
        pm.boot_rom <= 1'b1;
        wr_reg(SV, 8'h18);
        idle(5);
        chk(8'(fo), 8'h00);
        pm.boot_rom <= 1'b0;
        wr_reg(SV, 8'h18);
        wait_fo(1'b1, 3);
    endtask : t_power

    initial
    begin
        reset_n = 1'b0;
        {wr, rd, opt} = 3'h0;
        ic = 1'b1;
        tick = 1'b1;
        pm = '0;
        addr = 4'h0;
        wd = 8'h00;
        n_mismatch = 0;
        compares = 0;
        t_reset_vals;
        t_bad_key;
        t_windows;
        t_timeout;
        t_monitor;
        t_power;
        end_of_test;
    end
endmodule : tb
